// *** test/sample_source.sv ***
// Purpose: converter core side, feeds the I and Q sample streams
// Assumes: one sample per core_clk, launched on the falling edge
// Notes:   levels are held by the bench; a step gives a steady response
`timescale 1ns/1ps
module sample_source #(
    parameter int DW = 16
) (
    input  wire logic          core_clk,
    input  wire logic [DW-1:0] level_i,
    input  wire logic [DW-1:0] level_q,
    output logic      [DW-1:0] in_i,
    output logic      [DW-1:0] in_q
);
    // ==========================================================
    // stream drive
    initial begin
        in_i = '0;
        in_q = '0;
    end

    // launch away from the sampling edge so no race with the filter
    always @(negedge core_clk) begin
        in_i <= level_i;
        in_q <= level_q;
    end
endmodule

// *** test/test_loss_equalizer_fir.sv ***
// Purpose: self-checking bench of the loss equaliser filter
// Assumes: steady input levels, outputs compared once settled
// Notes:   one tap per bank X half and two per bank Y half keep every expected sum exact
`timescale 1ns/1ps
module test_loss_equalizer_fir;
    import loss_equalizer_fir_pkg::*;
    localparam int DW    = 16;
    localparam int LIMIT = 12000;

    // ==========================================================
    // signals
    logic          core_clk      = 1'b0;
    logic          arst_n        = 1'b0;
    logic [15:0]   reg_addr      = 16'h0000;
    logic [7:0]    reg_wdata     = 8'h00;
    logic          reg_wr        = 1'b0;
    logic          reg_rd        = 1'b0;
    logic [7:0]    reg_rdata;
    logic          coef_transfer = 1'b0;
    logic [DW-1:0] level_i       = 16'h1000;
    logic [DW-1:0] level_q       = 16'h0800;
    logic [DW-1:0] in_i;
    logic [DW-1:0] in_q;
    logic [DW-1:0] out_i;
    logic [DW-1:0] out_q;
    int            mismatches    = 0;
    int            checks_done   = 0;
    int            cycles        = 0;

    logic [15:0] rw_addr[6] = '{16'h0DF8, 16'h0DF9, 16'h0E80,
                                16'h0E7F, 16'h0F7F, 16'h0DF7};
    logic [7:0]  rw_data[6] = '{8'hFF, 8'hFF, 8'h33, 8'hA5, 8'h5A, 8'h11};
    logic [7:0]  rw_exp[6]  = '{8'h07, 8'h77, 8'h00, 8'hA5, 8'h5A, 8'h00};
    logic [15:0] cf_addr[6] = '{16'h0E00, 16'h0E40, 16'h0F00,
                                16'h0F28, 16'h0F40, 16'h0F68};
    logic [7:0]  cf_data[6] = '{8'h40, 8'h20, 8'h20, 8'h40, 8'h20, 8'h40};
    // steady outputs per mode code 0..7 (code 3 behaves as bypass)
    logic [15:0] md_i[8] = '{16'h1000, 16'h0800, 16'h1400, 16'h1000,
                             16'h0600, 16'h0E00, 16'h1000, 16'h0C00};
    logic [15:0] md_q[8] = '{16'h0800, 16'h0200, 16'h0800, 16'h0800,
                             16'h0180, 16'h0E00, 16'h1C00, 16'h0400};
    logic [2:0]  gn_code[5] = '{GAIN_UNITY, GAIN_UP6, GAIN_UP12,
                                GAIN_DN12, GAIN_DN6};
    logic [15:0] gn_i[5] = '{16'h0800, 16'h1000, 16'h2000,
                             16'h0200, 16'h0400};
    logic [15:0] gn_q[5] = '{16'h0200, 16'h0400, 16'h0800,
                             16'h0080, 16'h0100};

    // ==========================================================
    // clock, partner, design
    always #5 core_clk = ~core_clk;

    sample_source #(.DW(DW)) src (
        .core_clk (core_clk),
        .level_i  (level_i),
        .level_q  (level_q),
        .in_i     (in_i),
        .in_q     (in_q)
    );

    loss_equalizer_fir #(.DW(DW)) uut (
        .core_clk      (core_clk),
        .arst_n        (arst_n),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .coef_transfer (coef_transfer),
        .in_i          (in_i),
        .in_q          (in_q),
        .out_i         (out_i),
        .out_q         (out_q)
    );

    // ==========================================================
    // register port tasks
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
    endtask

    // chained reads follow a write with no idle cycle, so the back-to-back
    // write then read path of both banks is really exercised
    task automatic expect_reg(input logic [15:0] a, input logic [7:0] e,
                              input bit chained);
        if (!chained) begin
            @(negedge core_clk);
        end
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        checks_done++;
        if (reg_rdata !== e) begin
            mismatches++;
            $display("ERROR t=%0t reg %h read %h want %h",
                     $time, a, reg_rdata, e);
        end
    endtask

    // waits long enough for every delay line to fill with the step
    task automatic expect_out(input logic [15:0] ei, input logic [15:0] eq);
        repeat (140) @(negedge core_clk);
        checks_done++;
        if (out_i !== ei || out_q !== eq) begin
            mismatches++;
            $display("ERROR t=%0t out %h/%h want %h/%h",
                     $time, out_i, out_q, ei, eq);
        end
    endtask

    task automatic close_out;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("ERROR t=%0t run did not finish", $time);
            close_out();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;

        expect_reg(16'h0DF8, MODE_CONTROL_RESET, 1'b0);
        expect_reg(16'h0DF9, BANK_GAIN_RESET, 1'b0);
        expect_reg(16'h0E00, COEF_RESET, 1'b0);
        expect_reg(16'h0E7F, COEF_RESET, 1'b0);
        expect_reg(16'h0F00, COEF_RESET, 1'b0);
        expect_reg(16'h0F7F, COEF_RESET, 1'b0);
        expect_out(16'h1000, 16'h0800);
        for (int k = 0; k < 6; k++) begin
            reg_write(rw_addr[k], rw_data[k]);
            expect_reg(rw_addr[k], rw_exp[k], 1'b1);
            reg_write(rw_addr[k], 8'h00);
        end
        $display("test registers done");

        // pending coefficients must not reach the stream
        for (int k = 0; k < 6; k++) begin
            reg_write(cf_addr[k], cf_data[k]);
        end
        reg_write(FILTER_MODE_CONTROL_ADDR, 8'h01);
        expect_reg(16'h0F28, 8'h40, 1'b0);
        expect_out(16'h0000, 16'h0000);
        @(negedge core_clk);
        coef_transfer = 1'b1;
        @(negedge core_clk);
        coef_transfer = 1'b0;
        expect_out(16'h0800, 16'h0200);
        $display("test transfer done");

        for (int m = 0; m < 8; m++) begin
            reg_write(FILTER_MODE_CONTROL_ADDR, 8'(m));
            expect_out(md_i[m], md_q[m]);
        end
        $display("test modes done");

        reg_write(FILTER_MODE_CONTROL_ADDR, 8'h01);
        for (int g = 0; g < 5; g++) begin
            reg_write(FILTER_BANK_GAIN_ADDR, {5'h00, gn_code[g]});
            expect_out(gn_i[g], gn_q[g]);
        end
        // bank Y halved in cascade, bank X at unity
        reg_write(FILTER_MODE_CONTROL_ADDR, 8'h04);
        reg_write(FILTER_BANK_GAIN_ADDR, 8'h70);
        expect_out(16'h0300, 16'h00C0);
        $display("test gains done");
        close_out();
    end
endmodule

// *** verilog/fir_bank_filter.sv ***
// Purpose: one real FIR section with gain step and saturation
// Assumes: one new sample every clock
// Notes:   output registered, one cycle after the newest tap
`timescale 1ns/1ps
module fir_bank_filter
    import loss_equalizer_fir_pkg::*;
#(
    parameter int TAPS = FILTER_TAPS,
    parameter int DW   = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic [DW-1:0]          sample_in,
    input  wire logic [TAPS*COEF_W-1:0] coeffs,
    input  wire logic [2:0]             gain,
    output logic      [DW-1:0]          sample_out
);
    localparam int AW = DW + COEF_W + $clog2(TAPS);
    localparam int SW = AW + 2;
    localparam logic signed [SW-1:0] SAT_HI = SW'((2**(DW-1)) - 1);
    localparam logic signed [SW-1:0] SAT_LO = ~SAT_HI;

    logic        [TAPS-2:0][DW-1:0]   line_q;
    logic        [TAPS-1:0][DW-1:0]   tap;
    logic signed [DW+COEF_W-1:0]      prod [TAPS];
    logic signed [AW-1:0]             acc;
    logic signed [SW-1:0]             wide;
    logic signed [SW-1:0]             gained;
    logic        [DW-1:0]             next_out;

    // ==========================================================
    // taps and products
    assign tap[0] = sample_in;
    for (genvar k = 0; k < TAPS; k++) begin : g_tap
        if (k > 0) begin : g_line
            assign tap[k] = line_q[k-1];
        end
        assign prod[k] = $signed(tap[k]) *
                         $signed(coeffs[k*COEF_W +: COEF_W]);
    end

    always_comb begin
        acc = '0;
        for (int k = 0; k < TAPS; k++) begin
            acc = acc + AW'(prod[k]);
        end
    end

    // ==========================================================
    // gain step, then clip instead of wrapping
    assign wide   = SW'(acc >>> COEF_FRAC);
    assign gained = (gain == GAIN_UP6)  ? (wide <<< 1) :
                    (gain == GAIN_UP12) ? (wide <<< 2) :
                    (gain == GAIN_DN6)  ? (wide >>> 1) :
                    (gain == GAIN_DN12) ? (wide >>> 2) : wide;
    assign next_out = (gained > SAT_HI) ? SAT_HI[DW-1:0] :
                      (gained < SAT_LO) ? SAT_LO[DW-1:0] :
                      gained[DW-1:0];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q     <= '0;
            sample_out <= '0;
        end else begin
            line_q     <= {line_q[TAPS-3:0], sample_in};
            sample_out <= next_out;
        end
    end

endmodule

// *** verilog/loss_equalizer_fir.sv ***
// Purpose: channel loss equaliser, two coefficient banks, seven modes
// Assumes: continuous I/Q stream, one sample per core_clk
// Notes:   coefficients are double-buffered; reads return pending values
//
// How it works
// (R1) mode field bits 2:0, reset zero, zero passes samples straight through
// (R2) single mode filters I and Q by the matching half of bank X
// (R3) joined mode uses X then Y as one longer filter per stream
// (R4) cascade mode runs each stream through X then through Y
// (R5) complex mode sums X-filtered own path and Y-filtered cross path
// (R6) half complex passes I; Q sums combined Q and I filtered terms
// (R7) real long mode is a 96-tap combined filter per stream
// (R8) bank X: 128 byte coefficient locations, read/write, reset zero
// (R9) bank Y: 128 byte coefficient locations laid out like bank X
// (R10) coefficient writes stay pending until the transfer pulse
// (R11) per-bank three-bit gain: Y bits 6:4, X bits 2:0, zero unity
`timescale 1ns/1ps
module loss_equalizer_fir
    import loss_equalizer_fir_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    input  wire logic [15:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    input  wire logic          coef_transfer,
    input  wire logic [DW-1:0] in_i,
    input  wire logic [DW-1:0] in_q,
    output logic      [DW-1:0] out_i,
    output logic      [DW-1:0] out_q
);
    logic [2:0]                        mode;
    logic [2:0]                        gain_x;
    logic [2:0]                        gain_y;
    logic [COEF_COUNT-1:0][COEF_W-1:0] shadow;
    logic [COEF_COUNT-1:0][COEF_W-1:0] active;
    logic [FILTER_TAPS-1:0][COEF_W-1:0] c0;
    logic [FILTER_TAPS-1:0][COEF_W-1:0] c1;
    logic [FILTER_TAPS-1:0][COEF_W-1:0] c2;
    logic [FILTER_TAPS-1:0][COEF_W-1:0] c3;
    logic [DW-1:0]                     f0_out;
    logic [DW-1:0]                     f1_out;
    logic [DW-1:0]                     f2_out;
    logic [DW-1:0]                     f3_out;
    logic [DW-1:0]                     f2_in;
    logic [DW-1:0]                     f3_in;
    logic [DW-1:0]                     sum_i;
    logic [DW-1:0]                     sum_q;
    logic [DW-1:0]                     next_out_i;
    logic [DW-1:0]                     next_out_q;
    logic [7:0]                        next_rdata;
    logic [2:0]                        gain_f3;

    // ==========================================================
    // register decode
    logic       hit_mode;
    logic       hit_gain;
    logic       hit_x;
    logic       hit_y;
    logic       hit_coef;
    logic [7:0] coef_idx;

    assign hit_mode = (reg_addr == FILTER_MODE_CONTROL_ADDR);
    assign hit_gain = (reg_addr == FILTER_BANK_GAIN_ADDR);
    assign hit_x    = (reg_addr[15:7] == BANK_X_BASE[15:7]);
    assign hit_y    = (reg_addr[15:7] == BANK_Y_BASE[15:7]);
    assign hit_coef = hit_x | hit_y;
    assign coef_idx = {hit_y, reg_addr[6:0]};

    // unmapped and reserved bits read zero
    assign next_rdata = hit_mode ? {5'h00, mode} :
                        hit_gain ? {1'b0, gain_y, 1'b0, gain_x} :
                        hit_coef ? shadow[coef_idx] : 8'h00;

    // ==========================================================
    // control registers
    // (R1) mode field store
    // (R11) gain field store
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode   <= MODE_CONTROL_RESET[MODE_LSB +: 3];
            gain_x <= BANK_GAIN_RESET[GAIN_X_LSB +: 3];
            gain_y <= BANK_GAIN_RESET[GAIN_Y_LSB +: 3];
        end else if (reg_wr && hit_mode) begin
            mode <= reg_wdata[MODE_LSB +: 3];
        end else if (reg_wr && hit_gain) begin
            gain_x <= reg_wdata[GAIN_X_LSB +: 3];
            gain_y <= reg_wdata[GAIN_Y_LSB +: 3];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // coefficient banks
    // (R8) (R9) pending byte store
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shadow <= {COEF_COUNT{COEF_RESET}};
        end else if (reg_wr && hit_coef) begin
            shadow[coef_idx] <= reg_wdata;
        end
    end

    // (R10) whole-bank copy on transfer
    // copying all at once avoids a half-updated filter mid-stream
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            active <= {COEF_COUNT{COEF_RESET}};
        end else if (coef_transfer) begin
            active <= shadow;
        end
    end

    // ==========================================================
    // mode groups
    logic use_x;
    logic use_xy;
    logic is_long;

    assign use_x   = (mode == MODE_SINGLE_X) | (mode == MODE_CASCADE) |
                     (mode == MODE_COMPLEX);
    assign use_xy  = (mode == MODE_JOINED_BANKS) | (mode == MODE_REAL_LONG);
    assign is_long = (mode == MODE_REAL_LONG);

    // ==========================================================
    // per-tap coefficient routing
    for (genvar k = 0; k < FILTER_TAPS; k++) begin : g_coef
        localparam int KL = k % HALF_TAPS;
        localparam bit LOW = (k < HALF_TAPS);
        localparam bit IN_LONG = (k < REAL_LONG_TAPS);
        logic [COEF_W-1:0] xi_p;
        logic [COEF_W-1:0] xq_p;
        logic [COEF_W-1:0] yi_p;
        logic [COEF_W-1:0] yq_p;
        logic [COEF_W-1:0] xyi;
        logic [COEF_W-1:0] xyq;
        logic              cut;

        assign xi_p = LOW ? active[KL] : COEF_RESET;
        assign xq_p = LOW ? active[HALF_TAPS + KL] : COEF_RESET;
        assign yi_p = LOW ? active[2*HALF_TAPS + KL] : COEF_RESET;
        assign yq_p = LOW ? active[3*HALF_TAPS + KL] : COEF_RESET;
        assign xyi  = LOW ? active[KL] : active[2*HALF_TAPS + KL];
        assign xyq  = LOW ? active[HALF_TAPS + KL] : active[3*HALF_TAPS + KL];
        // (R7) taps past 96 forced to zero
        assign cut  = is_long & !IN_LONG;

        // (R2) (R3) first-stage coefficient sets
        assign c0[k] = use_x ? xi_p :
                       (use_xy && !cut) ? xyi : COEF_RESET;
        assign c1[k] = use_x ? xq_p :
                       ((use_xy || mode == MODE_HALF_COMPLEX) && !cut) ?
                       xyq : COEF_RESET;
        // (R4) (R5) (R6) second-stage coefficient sets
        assign c2[k] = (mode == MODE_CASCADE) ? yi_p :
                       (mode == MODE_COMPLEX) ? yq_p : COEF_RESET;
        assign c3[k] = (mode == MODE_CASCADE) ? yq_p :
                       (mode == MODE_COMPLEX) ? yi_p :
                       (mode == MODE_HALF_COMPLEX) ? xyi : COEF_RESET;
    end

    // ==========================================================
    // filter sections
    // (R4) cascade feeds bank X results into bank Y
    assign f2_in = (mode == MODE_CASCADE) ? f0_out : in_q;
    assign f3_in = (mode == MODE_CASCADE) ? f1_out : in_i;
    // (R11) joined sets on the cross section take the X gain
    assign gain_f3 = (mode == MODE_HALF_COMPLEX) ? gain_x : gain_y;

    fir_bank_filter #(.TAPS(FILTER_TAPS), .DW(DW)) u_f0 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sample_in  (in_i),
        .coeffs     (c0),
        .gain       (gain_x),
        .sample_out (f0_out)
    );
    fir_bank_filter #(.TAPS(FILTER_TAPS), .DW(DW)) u_f1 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sample_in  (in_q),
        .coeffs     (c1),
        .gain       (gain_x),
        .sample_out (f1_out)
    );
    fir_bank_filter #(.TAPS(FILTER_TAPS), .DW(DW)) u_f2 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sample_in  (f2_in),
        .coeffs     (c2),
        .gain       (gain_y),
        .sample_out (f2_out)
    );
    fir_bank_filter #(.TAPS(FILTER_TAPS), .DW(DW)) u_f3 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .sample_in  (f3_in),
        .coeffs     (c3),
        .gain       (gain_f3),
        .sample_out (f3_out)
    );

    // ==========================================================
    // output combine
    function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a,
                                              input logic [DW-1:0] b);
        logic signed [DW:0] s;
        s = $signed({a[DW-1], a}) + $signed({b[DW-1], b});
        if (s[DW] != s[DW-1]) begin
            return {s[DW], {(DW-1){~s[DW]}}};
        end
        return s[DW-1:0];
    endfunction

    // (R5) (R6) summed outputs
    assign sum_i = sat_add(f0_out, f2_out);
    assign sum_q = sat_add(f1_out, f3_out);

    always_comb begin
        next_out_i = in_i;
        next_out_q = in_q;
        case (mode)
            MODE_SINGLE_X, MODE_JOINED_BANKS, MODE_REAL_LONG: begin
                next_out_i = f0_out;
                next_out_q = f1_out;
            end
            MODE_CASCADE: begin
                next_out_i = f2_out;
                next_out_q = f3_out;
            end
            MODE_COMPLEX: begin
                next_out_i = sum_i;
                next_out_q = sum_q;
            end
            MODE_HALF_COMPLEX: begin
                next_out_i = in_i;
                next_out_q = sum_q;
            end
            default: begin
                next_out_i = in_i;
                next_out_q = in_q;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_i <= '0;
            out_q <= '0;
        end else begin
            out_i <= next_out_i;
            out_q <= next_out_q;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence x_wr_rd_s;
        reg_wr && hit_x ##1 reg_rd && !reg_wr &&
            reg_addr == $past(reg_addr);
    endsequence
    sequence y_wr_rd_s;
        reg_wr && hit_y ##1 reg_rd && !reg_wr &&
            reg_addr == $past(reg_addr);
    endsequence

    bypass_pass_a: assert property ( // (R1)
        mode == MODE_BYPASS |=> out_i == $past(in_i) && out_q == $past(in_q))
        else $error("bypass output does not follow input");
    single_sel_a: assert property ( // (R2)
        mode == MODE_SINGLE_X |=> out_i == $past(f0_out) &&
            out_q == $past(f1_out))
        else $error("single mode output not from bank X");
    joined_taps_a: assert property ( // (R3)
        mode == MODE_JOINED_BANKS |-> c0[HALF_TAPS] == active[2*HALF_TAPS])
        else $error("joined filter lacks bank Y taps");
    cascade_chain_a: assert property ( // (R4)
        mode == MODE_CASCADE |-> f2_in == f0_out ##1 out_i == $past(f2_out))
        else $error("cascade chain broken");
    complex_sum_a: assert property ( // (R5)
        mode == MODE_COMPLEX |=> out_i == $past(sum_i) &&
            out_q == $past(sum_q))
        else $error("complex output not the summed terms");
    half_pass_a: assert property ( // (R6)
        mode == MODE_HALF_COMPLEX |=> out_i == $past(in_i) &&
            out_q == $past(sum_q))
        else $error("half complex output wrong");
    long_cut_a: assert property ( // (R7)
        is_long |-> c0[REAL_LONG_TAPS] == COEF_RESET &&
            c1[FILTER_TAPS-1] == COEF_RESET)
        else $error("long filter taps past limit not zero");
    x_readback_a: assert property ( // (R8)
        x_wr_rd_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("bank X readback mismatch");
    y_readback_a: assert property ( // (R9)
        y_wr_rd_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("bank Y readback mismatch");
    pending_hold_a: assert property ( // (R10)
        !coef_transfer |=> active == $past(active))
        else $error("active coefficients changed without transfer");
    gain_store_a: assert property ( // (R11)
        reg_wr && hit_gain |=> gain_x == $past(reg_wdata[2:0]) &&
            gain_y == $past(reg_wdata[6:4]))
        else $error("gain fields not stored");

endmodule

// *** verilog/loss_equalizer_fir_pkg.sv ***
// Purpose: shared constants and types of the loss equaliser filter
// Assumes: byte-wide register port, 16-bit register addresses
// Notes:   coefficient numeric format is a plain signed byte, COEF_FRAC
//          fraction bits
package loss_equalizer_fir_pkg;

    // ==========================================================
    // register map
    localparam logic [15:0] FILTER_MODE_CONTROL_ADDR = 16'h0DF8;
    localparam logic [15:0] FILTER_BANK_GAIN_ADDR    = 16'h0DF9;
    localparam logic [15:0] BANK_X_BASE              = 16'h0E00;
    localparam logic [15:0] BANK_Y_BASE              = 16'h0F00;

    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BANK_GAIN_RESET    = 8'h00;
    localparam logic [7:0] COEF_RESET         = 8'h00;

    localparam int MODE_LSB   = 0;
    localparam int GAIN_X_LSB = 0;
    localparam int GAIN_Y_LSB = 4;

    // ==========================================================
    // bank geometry
    localparam int COEF_W         = 8;
    localparam int BANK_DEPTH     = 128;
    localparam int COEF_COUNT     = 256;
    localparam int HALF_TAPS      = 64;
    localparam int FILTER_TAPS    = 128;
    localparam int REAL_LONG_TAPS = 96;
    localparam int COEF_FRAC      = 7;

    // ==========================================================
    // mode and gain codes
    typedef enum logic [2:0] {
        MODE_BYPASS       = 3'h0,
        MODE_SINGLE_X     = 3'h1,
        MODE_JOINED_BANKS = 3'h2,
        MODE_CASCADE      = 3'h4,
        MODE_COMPLEX      = 3'h5,
        MODE_HALF_COMPLEX = 3'h6,
        MODE_REAL_LONG    = 3'h7
    } filter_mode_t;

    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic [2:0] GAIN_UP6   = 3'h1;
    localparam logic [2:0] GAIN_UP12  = 3'h2;
    localparam logic [2:0] GAIN_DN12  = 3'h6;
    localparam logic [2:0] GAIN_DN6   = 3'h7;

endpackage
